// ### rtl/rcrs_params.svh
// Constants of the core register set: indices, fields, offsets and resets.
`ifndef RCRS_PARAMS_SVH
`define RCRS_PARAMS_SVH

// Internal register indices.
`define RCRS_REG_R0      4'h0
`define RCRS_REG_OFFSET  4'h3
`define RCRS_REG_I0H     4'h4
`define RCRS_REG_I0L     4'h5
`define RCRS_REG_I1H     4'h6
`define RCRS_REG_I1L     4'h7
`define RCRS_REG_I2H     4'h8
`define RCRS_REG_I2L     4'h9
`define RCRS_REG_I3H     4'ha
`define RCRS_REG_I3L     4'hb
`define RCRS_REG_IPH     4'hc
`define RCRS_REG_IPL     4'hd
`define RCRS_REG_STAT    4'he
`define RCRS_REG_ACC     4'hf

// Status byte bit positions.
`define RCRS_ST_IE2      7
`define RCRS_ST_IE1      6
`define RCRS_ST_GIE      5
`define RCRS_ST_IN2      4
`define RCRS_ST_IN1      3
`define RCRS_ST_IN0      2
`define RCRS_ST_EV1      1
`define RCRS_ST_EV0      0

// Instruction word layout.
`define RCRS_IW_W        22
`define RCRS_IW_OPC_HI   21
`define RCRS_IW_OPC_LO   16
`define RCRS_IW_R1_HI    15
`define RCRS_IW_R1_LO    12
`define RCRS_IW_MODE_HI  11
`define RCRS_IW_MODE_LO  9
`define RCRS_IW_R2_HI    7
`define RCRS_IW_R2_LO    4

// Operand addressing modes.
`define RCRS_AM_REG      3'h0
`define RCRS_AM_IMM      3'h1
`define RCRS_AM_DIRECT   3'h2
`define RCRS_AM_I0       3'h3
`define RCRS_AM_I1       3'h4
`define RCRS_AM_I2       3'h5
`define RCRS_AM_I3       3'h6
`define RCRS_AM_I0_OFS   3'h7

// Bus word offsets beyond the sixteen register words.
`define RCRS_WB_PC       8'h40
`define RCRS_WB_FLAGS    8'h44
`define RCRS_WB_STKTOP   8'h48

// Reset values and the interrupt entry address.
`define RCRS_STAT_RST    8'h00
`define RCRS_PC_RST      16'h0000
`define RCRS_IRQ_VECTOR  16'h0001

`endif

// ### rtl/rcrs_pkg.sv
// Types shared by the core register set.
package rcrs_pkg;
  typedef logic [7:0]  rcrs_byte_t;
  typedef logic [15:0] rcrs_word_t;
  typedef logic [21:0] rcrs_iword_t;
  typedef enum logic [5:0] {
    OP_NOP, OP_JUMP, OP_JUMPIP, OP_JZ, OP_JNZ, OP_JC, OP_JNC, OP_JV,
    OP_JNV, OP_CALL, OP_CALLIP, OP_CALLS, OP_RET, OP_RETS, OP_RETI,
    OP_PUSH, OP_POP, OP_MOVE, OP_STORE, OP_CMVD, OP_CMVS, OP_SHL,
    OP_SHLC, OP_SHR, OP_SHRC, OP_SHRA, OP_CPL1, OP_CPL2, OP_INC, OP_DEC,
    OP_ADD, OP_ADDC, OP_SUB, OP_SUBC, OP_AND, OP_OR, OP_XOR, OP_MUL,
    OP_HALT
  } rcrs_op_t;
endpackage : rcrs_pkg

// ### rtl/rcrs_core.sv
// Single-cycle core register set, flags, counter, stack and wake logic.
//
// Register access over Wishbone and the register offsets were left to the implementer.
`include "rcrs_params.svh"

// What this block does
// - Sixteen directly addressed 8-bit registers.
// - Decode 22-bit instruction words with eight operand addressing modes.
// - Every instruction, jumps and multiply included, completes in one cycle.
// - Register pairs join into 16-bit operands, high byte on top.
// - A 16-bit instruction counter holds the next instruction address.
// - The return stack saves return addresses on CALL, CALLIP and interrupts; CALLS saves it in the ip pair.
// - After halt, interrupts vector and events resume at the next word.
// - Four 16-bit data indexes are built from high and low bytes.
// - A 16-bit program index is built from high and low bytes.
// - Status bits 7 and 6 enable levels 2 and 1 when one.
// - Status bit 5 is the global interrupt enable.
// - Status bits 4, 3, 2 hold interrupt requests of levels 2, 1, 0.
// - Status bits 1 and 0 hold event requests, cleared by software.
// - Zero flag is one exactly when the accumulator is zero.
// - Shifts put the bit shifted out into carry.
// - Unsigned addition overflow sets carry to one.
// - Unsigned subtraction underflow clears carry to zero.
// - Signed overflow or underflow sets the overflow flag.
// - Return from interrupt pops the counter and sets the global enable.
module rcrs_core #(
  parameter int                  STACK_DEPTH = 4,
  parameter logic [15:0]         IRQ_VECTOR  = `RCRS_IRQ_VECTOR
) (
  input  wire logic              CORE_CLK,
  input  wire logic              NRST,
  input  wire logic              WB_CYC_I,
  input  wire logic              WB_STB_I,
  input  wire logic              WB_WE_I,
  input  wire logic [7:0]        WB_ADR_I,
  input  wire logic [3:0]        WB_SEL_I,
  input  wire logic [31:0]       WB_DAT_I,
  output logic      [31:0]       WB_DAT_O,
  output logic                   WB_ACK_O,
  output rcrs_pkg::rcrs_word_t   PM_ADDR,
  input  wire rcrs_pkg::rcrs_iword_t PM_INSTR,
  output rcrs_pkg::rcrs_word_t   DM_ADDR,
  input  wire rcrs_pkg::rcrs_byte_t  DM_RDATA,
  output rcrs_pkg::rcrs_byte_t   DM_WDATA,
  output logic                   DM_WE,
  input  wire logic              IRQ_LOW,
  input  wire logic              IRQ_MID,
  input  wire logic              IRQ_HIGH,
  input  wire logic              EVT_LOW,
  input  wire logic              EVT_HIGH,
  output logic                   IRQ_TAKEN,
  output logic                   HALTED,
  output logic                   ZERO_FLAG,
  output rcrs_pkg::rcrs_byte_t   STATUS
);
  import rcrs_pkg::*;

  // The stack shifts down by one entry, so it needs at least two words.
  generate
    if (STACK_DEPTH < 2) begin : g_bad_depth
      $error("STACK_DEPTH must be at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [15:0][7:0]             regs;
    logic [15:0]                  pc;
    logic [STACK_DEPTH-1:0][15:0] stk;
    logic                         c;
    logic                         v;
    logic                         halted;
    logic                         ack;
    logic [31:0]                  rdat;
  } rcrs_state_t;

  rcrs_state_t s_r;
  rcrs_state_t s_nxt;

  // Joins a high and a low register into one 16-bit operand.
  function automatic rcrs_word_t pair16(input rcrs_byte_t hi,
                                        input rcrs_byte_t lo);
    return {hi, lo};
  endfunction

  // Nine-bit sum with carry in; bit 8 is the unsigned carry out.
  function automatic logic [8:0] add9(input rcrs_byte_t x,
                                      input rcrs_byte_t y,
                                      input logic cin);
    return {1'b0, x} + {1'b0, y} + {8'h00, cin};
  endfunction

  rcrs_op_t   op;
  logic [3:0] r1;
  logic [3:0] r2;
  logic [2:0] mode;
  rcrs_byte_t imm;
  rcrs_byte_t src;
  rcrs_byte_t dst;
  rcrs_byte_t res;
  rcrs_byte_t stat;
  rcrs_word_t pc_inc;
  rcrs_word_t idx_ip;
  logic [8:0]  sum;
  logic [15:0] prod;
  logic        wr_res;
  logic        lvl_go;
  logic        evt_go;
  logic        wb_req;
  logic        wb_wr;
  logic [3:0]  wb_idx;

  // Instruction fields; unused opcodes decode as no operation.
  always_comb begin
    op = OP_NOP;
    if (PM_INSTR[`RCRS_IW_OPC_HI:`RCRS_IW_OPC_LO] <= OP_HALT) begin
      op = rcrs_op_t'(PM_INSTR[`RCRS_IW_OPC_HI:`RCRS_IW_OPC_LO]);
    end
  end
  assign r1   = PM_INSTR[`RCRS_IW_R1_HI:`RCRS_IW_R1_LO];
  assign r2   = PM_INSTR[`RCRS_IW_R2_HI:`RCRS_IW_R2_LO];
  assign mode = PM_INSTR[`RCRS_IW_MODE_HI:`RCRS_IW_MODE_LO];
  assign imm  = PM_INSTR[7:0];

  // Interrupt levels: 0 needs only the global enable, 1 and 2 their own.
  assign stat   = s_r.regs[`RCRS_REG_STAT];
  assign lvl_go = stat[`RCRS_ST_GIE] & (stat[`RCRS_ST_IN0] |
                  (stat[`RCRS_ST_IN1] & stat[`RCRS_ST_IE1]) |
                  (stat[`RCRS_ST_IN2] & stat[`RCRS_ST_IE2]));
  assign evt_go = stat[`RCRS_ST_EV1] | stat[`RCRS_ST_EV0];

  // Bus request seen in its first cycle, and its write at the ack edge.
  assign wb_req = WB_CYC_I & WB_STB_I & ~s_r.ack;
  assign wb_wr  = WB_CYC_I & WB_STB_I & WB_WE_I & s_r.ack;
  assign wb_idx = WB_ADR_I[5:2];

  // Operand fetch: register, immediate, or data memory, direct or through an index.
  always_comb begin
    DM_ADDR = {8'h00, imm};
    case (mode)
      `RCRS_AM_I0: DM_ADDR = pair16(s_r.regs[`RCRS_REG_I0H],
                                    s_r.regs[`RCRS_REG_I0L]);
      `RCRS_AM_I1: DM_ADDR = pair16(s_r.regs[`RCRS_REG_I1H],
                                    s_r.regs[`RCRS_REG_I1L]);
      `RCRS_AM_I2: DM_ADDR = pair16(s_r.regs[`RCRS_REG_I2H],
                                    s_r.regs[`RCRS_REG_I2L]);
      `RCRS_AM_I3: DM_ADDR = pair16(s_r.regs[`RCRS_REG_I3H],
                                    s_r.regs[`RCRS_REG_I3L]);
      `RCRS_AM_I0_OFS: DM_ADDR = pair16(s_r.regs[`RCRS_REG_I0H],
                                        s_r.regs[`RCRS_REG_I0L]) +
                                 {8'h00, s_r.regs[`RCRS_REG_OFFSET]};
      default: DM_ADDR = {8'h00, imm};
    endcase
    case (mode)
      `RCRS_AM_REG: src = s_r.regs[r2];
      `RCRS_AM_IMM: src = imm;
      default:      src = DM_RDATA;
    endcase
  end

  assign dst    = s_r.regs[r1];
  assign idx_ip = pair16(s_r.regs[`RCRS_REG_IPH],
                         s_r.regs[`RCRS_REG_IPL]);
  assign pc_inc = s_r.pc + 16'h0001;
  assign prod   = {8'h00, dst} * {8'h00, src};

  // Next state: interrupt entry, wake-up, one instruction, then bus access.
  always_comb begin
    s_nxt     = s_r;
    res       = src;
    sum       = 9'h000;
    wr_res    = 1'b0;
    DM_WE     = 1'b0;
    DM_WDATA  = dst;
    IRQ_TAKEN = 1'b0;
    s_nxt.ack = wb_req;
    if (s_r.halted && !lvl_go) begin
      // An event leaves the counter where halt left it, past the halt.
      if (evt_go) begin
        s_nxt.halted = 1'b0;
      end
    end else if (lvl_go) begin
      // Entry saves the address that would have run next.
      IRQ_TAKEN    = 1'b1;
      s_nxt.halted = 1'b0;
      s_nxt.stk    = {s_r.stk[STACK_DEPTH-2:0], s_r.pc};
      s_nxt.pc     = IRQ_VECTOR;
      s_nxt.regs[`RCRS_REG_STAT][`RCRS_ST_GIE] = 1'b0;
    end else begin
      // Every operation retires in this one cycle.
      s_nxt.pc = pc_inc;
      case (op)
        OP_JUMP:   s_nxt.pc = PM_INSTR[15:0];
        OP_JUMPIP: s_nxt.pc = idx_ip;
        OP_JZ:     if (ZERO_FLAG) s_nxt.pc = PM_INSTR[15:0];
        OP_JNZ:    if (!ZERO_FLAG) s_nxt.pc = PM_INSTR[15:0];
        OP_JC:     if (s_r.c) s_nxt.pc = PM_INSTR[15:0];
        OP_JNC:    if (!s_r.c) s_nxt.pc = PM_INSTR[15:0];
        OP_JV:     if (s_r.v) s_nxt.pc = PM_INSTR[15:0];
        OP_JNV:    if (!s_r.v) s_nxt.pc = PM_INSTR[15:0];
        OP_CALL, OP_CALLIP: begin
          s_nxt.stk = {s_r.stk[STACK_DEPTH-2:0], pc_inc};
          s_nxt.pc  = (op == OP_CALL) ? PM_INSTR[15:0] : idx_ip;
        end
        OP_CALLS: begin
          s_nxt.regs[`RCRS_REG_IPH] = pc_inc[15:8];
          s_nxt.regs[`RCRS_REG_IPL] = pc_inc[7:0];
          s_nxt.pc = PM_INSTR[15:0];
        end
        OP_RET, OP_RETI: begin
          s_nxt.pc = s_r.stk[0];
          s_nxt.stk[STACK_DEPTH-2:0] = s_r.stk[STACK_DEPTH-1:1];
          if (op == OP_RETI) begin
            s_nxt.regs[`RCRS_REG_STAT][`RCRS_ST_GIE] = 1'b1;
          end
        end
        OP_RETS:   s_nxt.pc = idx_ip;
        OP_PUSH:   s_nxt.stk = {s_r.stk[STACK_DEPTH-2:0], idx_ip};
        OP_POP: begin
          s_nxt.regs[`RCRS_REG_IPH] = s_r.stk[0][15:8];
          s_nxt.regs[`RCRS_REG_IPL] = s_r.stk[0][7:0];
          s_nxt.stk[STACK_DEPTH-2:0] = s_r.stk[STACK_DEPTH-1:1];
        end
        OP_MOVE: begin
          res    = src;
          wr_res = 1'b1;
        end
        OP_STORE:  DM_WE = 1'b1;
        OP_CMVD, OP_CMVS: begin
          // Accumulator always loads; destination only on the carry test.
          s_nxt.regs[`RCRS_REG_ACC] = src;
          if (s_r.c == (op == OP_CMVS)) begin
            s_nxt.regs[r1] = src;
          end
        end
        OP_SHL, OP_SHLC: begin
          res     = {src[6:0], (op == OP_SHLC) ? s_r.c : 1'b0};
          s_nxt.c = src[7];
          s_nxt.v = src[7] ^ src[6];
          wr_res  = 1'b1;
        end
        OP_SHR, OP_SHRC, OP_SHRA: begin
          case (op)
            OP_SHRC: res = {s_r.c, src[7:1]};
            OP_SHRA: res = {src[7], src[7:1]};
            default: res = {1'b0, src[7:1]};
          endcase
          s_nxt.c = src[0];
          s_nxt.v = 1'b0;
          wr_res  = 1'b1;
        end
        OP_CPL1: begin
          res    = ~src;
          wr_res = 1'b1;
        end
        OP_CPL2: begin
          sum     = add9(~src, 8'h00, 1'b1);
          res     = sum[7:0];
          s_nxt.c = (sum[7:0] == 8'h00);
          s_nxt.v = (src == 8'h80);
          wr_res  = 1'b1;
        end
        OP_INC: begin
          sum     = add9(src, 8'h00, 1'b1);
          res     = sum[7:0];
          s_nxt.c = sum[8];
          s_nxt.v = (src == 8'h7f);
          wr_res  = 1'b1;
        end
        OP_DEC: begin
          sum     = add9(src, 8'hff, 1'b0);
          res     = sum[7:0];
          s_nxt.c = sum[8];
          s_nxt.v = (src == 8'h80);
          wr_res  = 1'b1;
        end
        OP_ADD, OP_ADDC: begin
          sum     = add9(dst, src, (op == OP_ADDC) & s_r.c);
          res     = sum[7:0];
          s_nxt.c = sum[8];
          s_nxt.v = (dst[7] == src[7]) && (sum[7] != dst[7]);
          wr_res  = 1'b1;
        end
        OP_SUB, OP_SUBC: begin
          // Subtraction adds the complement, so carry is the not-borrow.
          sum     = add9(dst, ~src, (op == OP_SUBC) ? s_r.c : 1'b1);
          res     = sum[7:0];
          s_nxt.c = sum[8];
          s_nxt.v = (dst[7] != src[7]) && (sum[7] != dst[7]);
          wr_res  = 1'b1;
        end
        OP_AND: begin
          res    = dst & src;
          wr_res = 1'b1;
        end
        OP_OR: begin
          res    = dst | src;
          wr_res = 1'b1;
        end
        OP_XOR: begin
          res    = dst ^ src;
          wr_res = 1'b1;
        end
        OP_MUL: begin
          // High half to the destination, low half to the accumulator.
          s_nxt.regs[r1] = prod[15:8];
          s_nxt.regs[`RCRS_REG_ACC] = prod[7:0];
        end
        OP_HALT:   s_nxt.halted = 1'b1;
        default:   s_nxt.pc = pc_inc;
      endcase
      if (wr_res) begin
        s_nxt.regs[`RCRS_REG_ACC] = res;
        s_nxt.regs[r1] = res;
      end
    end

    // Bus reads sample at the request edge; writes land at the ack edge.
    s_nxt.rdat = 32'h0000_0000;
    if (wb_req && !WB_WE_I) begin
      if (WB_ADR_I[7:6] == 2'b00) begin
        s_nxt.rdat = {24'h00_0000, s_r.regs[wb_idx]};
      end else if (WB_ADR_I == `RCRS_WB_PC) begin
        s_nxt.rdat = {16'h0000, s_r.pc};
      end else if (WB_ADR_I == `RCRS_WB_FLAGS) begin
        s_nxt.rdat = {28'h000_0000, s_r.halted, s_r.v, s_r.c, ZERO_FLAG};
      end else if (WB_ADR_I == `RCRS_WB_STKTOP) begin
        s_nxt.rdat = {16'h0000, s_r.stk[0]};
      end
    end
    // A bus write overrides the core in the same cycle; it is a debug path.
    if (wb_wr && WB_SEL_I[0]) begin
      if (WB_ADR_I[7:6] == 2'b00) begin
        s_nxt.regs[wb_idx] = WB_DAT_I[7:0];
      end else if (WB_ADR_I == `RCRS_WB_PC) begin
        s_nxt.pc[7:0] = WB_DAT_I[7:0];
      end else if (WB_ADR_I == `RCRS_WB_FLAGS) begin
        s_nxt.c = WB_DAT_I[1];
        s_nxt.v = WB_DAT_I[2];
      end
    end
    if (wb_wr && WB_SEL_I[1] && WB_ADR_I == `RCRS_WB_PC) begin
      s_nxt.pc[15:8] = WB_DAT_I[15:8];
    end

    // Request pulses are merged last so that no clear can swallow them.
    s_nxt.regs[`RCRS_REG_STAT][`RCRS_ST_IN2] =
      s_nxt.regs[`RCRS_REG_STAT][`RCRS_ST_IN2] | IRQ_LOW;
    s_nxt.regs[`RCRS_REG_STAT][`RCRS_ST_IN1] =
      s_nxt.regs[`RCRS_REG_STAT][`RCRS_ST_IN1] | IRQ_MID;
    s_nxt.regs[`RCRS_REG_STAT][`RCRS_ST_IN0] =
      s_nxt.regs[`RCRS_REG_STAT][`RCRS_ST_IN0] | IRQ_HIGH;
    s_nxt.regs[`RCRS_REG_STAT][`RCRS_ST_EV1] =
      s_nxt.regs[`RCRS_REG_STAT][`RCRS_ST_EV1] | EVT_LOW;
    s_nxt.regs[`RCRS_REG_STAT][`RCRS_ST_EV0] =
      s_nxt.regs[`RCRS_REG_STAT][`RCRS_ST_EV0] | EVT_HIGH;
  end

  // State register; reset leaves interrupts off until software enables.
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      s_r <= '0;
      s_r.pc <= `RCRS_PC_RST;
      s_r.regs[`RCRS_REG_STAT] <= `RCRS_STAT_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs come from the state register; the zero flag is decoded from the accumulator.
  assign PM_ADDR   = s_r.pc;
  assign WB_ACK_O  = s_r.ack;
  assign WB_DAT_O  = s_r.rdat;
  assign HALTED    = s_r.halted;
  assign STATUS    = s_r.regs[`RCRS_REG_STAT];
  assign ZERO_FLAG = (s_r.regs[`RCRS_REG_ACC] == 8'h00);

endmodule // rcrs_core

// ### verification/rcrs_core_checker.sv
// Concurrent checks on the ports of the core register set.
module rcrs_core_checker #(
  parameter logic [15:0] IRQ_VECTOR = 16'h0001
) (
  input wire logic                 CORE_CLK,
  input wire logic                 NRST,
  input wire logic                 WB_CYC_I,
  input wire logic                 WB_STB_I,
  input wire logic                 WB_ACK_O,
  input wire rcrs_pkg::rcrs_word_t PM_ADDR,
  input wire logic                 IRQ_LOW,
  input wire logic                 IRQ_MID,
  input wire logic                 IRQ_HIGH,
  input wire logic                 EVT_LOW,
  input wire logic                 EVT_HIGH,
  input wire logic                 IRQ_TAKEN,
  input wire logic                 HALTED,
  input wire rcrs_pkg::rcrs_byte_t STATUS
);
  timeunit 1ns;
  timeprecision 1ps;
  import rcrs_pkg::*;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!NRST);

  // An unanswered strobe is a request; its answer is a single-cycle ack.
  sequence wb_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence ack_pulse;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence

  // Enabled pending interrupt; level 0 is gated by the global enable only.
  logic go;
  assign go = STATUS[5] && (STATUS[2] || (STATUS[3] && STATUS[6]) ||
              (STATUS[4] && STATUS[7]));

  property req_sets(logic s, logic b);
    s |=> b;
  endproperty

  ack_pulse_a: assert property (wb_req |=> ack_pulse)
    else $error("bus answer missing or longer than one cycle");
  ack_cause_a: assert property (WB_ACK_O |-> $past(WB_STB_I))
    else $error("bus ack without a request");
  irq_cause_a: assert property (IRQ_TAKEN |-> go)
    else $error("interrupt entry without an enabled request");
  irq_prompt_a: assert property (go |-> ##[0:1] IRQ_TAKEN)
    else $error("enabled interrupt request not taken");
  irq_entry_a: assert property (IRQ_TAKEN |=>
    !STATUS[5] && PM_ADDR == IRQ_VECTOR)
    else $error("interrupt entry did not vector or mask");
  halt_hold_a: assert property ((HALTED && !STATUS[1] && !STATUS[0] &&
    !IRQ_TAKEN) |=> $stable(PM_ADDR))
    else $error("counter moved while asleep");
  halt_wake_a: assert property ((HALTED && (STATUS[1] || STATUS[0]))
    |-> ##[1:3] !HALTED)
    else $error("pending event did not wake the core");
  req_low_a: assert property (req_sets(IRQ_LOW, STATUS[4]))
    else $error("low interrupt request not latched");
  req_mid_a: assert property (req_sets(IRQ_MID, STATUS[3]))
    else $error("mid interrupt request not latched");
  req_high_a: assert property (req_sets(IRQ_HIGH, STATUS[2]))
    else $error("high interrupt request not latched");
  evt_low_a: assert property (req_sets(EVT_LOW, STATUS[1]))
    else $error("low event request not latched");
  evt_high_a: assert property (req_sets(EVT_HIGH, STATUS[0]))
    else $error("high event request not latched");
endmodule // rcrs_core_checker

// ### verification/rcrs_mem_model.sv
// Program and data memory model facing the core's memory ports.
module rcrs_mem_model (
  input  wire logic                  CORE_CLK,
  input  wire rcrs_pkg::rcrs_word_t  PM_ADDR,
  output rcrs_pkg::rcrs_iword_t      PM_INSTR,
  input  wire rcrs_pkg::rcrs_word_t  DM_ADDR,
  output rcrs_pkg::rcrs_byte_t       DM_RDATA,
  input  wire rcrs_pkg::rcrs_byte_t  DM_WDATA,
  input  wire logic                  DM_WE
);
  timeunit 1ns;
  timeprecision 1ps;
  import rcrs_pkg::*;
  rcrs_iword_t prog [64];
  rcrs_byte_t  dm   [65536];
  // Asynchronous program store; beyond its end it reads as a no-op.
  assign PM_INSTR = (PM_ADDR < 16'h0040) ? prog[PM_ADDR[5:0]] : '0;
  // Same-cycle read; a store lands at the edge that ends its cycle.
  assign DM_RDATA = dm[DM_ADDR];
  always @(posedge CORE_CLK) begin
    if (DM_WE === 1'b1) begin
      dm[DM_ADDR] <= DM_WDATA;
    end
  end
endmodule // rcrs_mem_model

// ### verification/testbench.sv
// Self-checking bench of the core register set with a memory model.
`include "rcrs_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import rcrs_pkg::*;
  logic        clk, nrst, cyc, stb, we, ack, irq_taken, halted, zflag;
  logic        dm_we, sh;
  logic [7:0]  adr, a, b;
  logic [31:0] wdat, rdat, dat_o, r, seed;
  logic [4:0]  src;
  logic [17:0] e;
  rcrs_word_t  pm_addr, dm_addr;
  rcrs_iword_t pm_instr;
  rcrs_byte_t  dm_rdata, dm_wdata, status;
  int          errors, tests_run, taken;
  rcrs_op_t    ops [5] = '{OP_ADD, OP_SUB, OP_SHL, OP_SHR, OP_MUL};

  rcrs_core dut (.CORE_CLK(clk), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat),
    .WB_DAT_O(dat_o), .WB_ACK_O(ack), .PM_ADDR(pm_addr),
    .PM_INSTR(pm_instr), .DM_ADDR(dm_addr), .DM_RDATA(dm_rdata),
    .DM_WDATA(dm_wdata), .DM_WE(dm_we), .IRQ_LOW(src[4]), .IRQ_MID(src[3]),
    .IRQ_HIGH(src[2]), .EVT_LOW(src[1]), .EVT_HIGH(src[0]),
    .IRQ_TAKEN(irq_taken), .HALTED(halted), .ZERO_FLAG(zflag),
    .STATUS(status));
  rcrs_mem_model u_mem (.CORE_CLK(clk), .PM_ADDR(pm_addr),
    .PM_INSTR(pm_instr), .DM_ADDR(dm_addr), .DM_RDATA(dm_rdata),
    .DM_WDATA(dm_wdata), .DM_WE(dm_we));

  // Free-running core clock at 250 MHz.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Counts interrupt entries seen at the ports.
  always @(posedge clk) begin
    if (irq_taken === 1'b1) taken <= taken + 1;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic rcrs_iword_t enc(rcrs_op_t op, logic [3:0] r1,
                                      logic [2:0] md, logic [7:0] im);
    return {op, r1, md, 1'b0, im};
  endfunction
  function automatic rcrs_iword_t jmp(rcrs_op_t op, logic [15:0] t);
    return {op, t};
  endfunction
  // Expected {carry, overflow, destination, accumulator} of one operation.
  function automatic logic [17:0] alu(rcrs_op_t op, logic [7:0] x,
                                      logic [7:0] y);
    logic [8:0]  s;
    logic [7:0]  d;
    logic [15:0] p;
    s = {1'b0, x} + {1'b0, y};
    d = x - y;
    p = x * y;
    case (op)
      OP_ADD: return {s[8], x[7] == y[7] && s[7] != x[7], s[7:0], s[7:0]};
      OP_SUB: return {x >= y, x[7] != y[7] && d[7] != x[7], d, d};
      OP_SHL: return {x[7], x[7] ^ x[6], x << 1, x << 1};
      OP_SHR: return {x[0], 1'b0, x >> 1, x >> 1};
      default: return {2'b00, p[15:8], p[7:0]};
    endcase
  endfunction

  task automatic cmp(logic [15:0] got, logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic cycle; the request stands until ack is sampled high.
  task automatic wb(logic w, logic [7:0] ad, logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= d;
    // A missing answer is left to the watchdog, which ends the run.
    do @(posedge clk); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic pulse(logic [4:0] s);
    @(posedge clk);
    src <= s;
    @(posedge clk);
    src <= 5'h00;
  endtask
  task automatic restart();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (30) @(posedge clk);
  endtask
  task automatic pg(int ad, rcrs_iword_t w);
    u_mem.prog[ad] = w;
  endtask
  // Entry jump plus a service routine that clears the pending requests.
  task automatic base();
    for (int i = 0; i < 64; i++) pg(i, '0);
    pg(0, jmp(OP_JUMP, 16'h0010));
    pg(1, enc(OP_MOVE, `RCRS_REG_STAT, `RCRS_AM_IMM, 8'h40));
    pg(2, jmp(OP_RETI, 16'h0000));
  endtask
  task automatic print_verdict();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // The whole sequence needs just over a thousand cycles; this leaves wide margin.
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    print_verdict();
  end

  initial begin
    seed = 32'h0000_d62f;
    errors = 0;
    tests_run = 0;
    taken = 0;
    nrst = 1'b0;
    {cyc, stb, we, adr, wdat, src} = '0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    // Arithmetic and shifts: corner operands first, then random ones.
    for (int o = 0; o < 5; o++) begin
      for (int k = 0; k < 4; k++) begin
        r = xs();
        a = (k == 0) ? 8'hff : (k == 1) ? 8'h80 : r[7:0];
        b = (k < 2) ? 8'h01 : r[15:8];
        sh = (ops[o] == OP_SHL || ops[o] == OP_SHR);
        e = alu(ops[o], a, b);
        base();
        pg(16, enc(OP_MOVE, 4'h0, `RCRS_AM_IMM, a));
        pg(17, sh ? enc(ops[o], 4'h0, `RCRS_AM_REG, 8'h00)
                  : enc(ops[o], 4'h0, `RCRS_AM_IMM, b));
        pg(18, jmp(OP_JUMP, 16'h0012));
        restart();
        wb(1'b0, 8'h00, 32'h0);
        cmp(rdat[15:0], {8'h00, e[15:8]});
        wb(1'b0, 8'h3c, 32'h0);
        cmp(rdat[15:0], {8'h00, e[7:0]});
        wb(1'b0, `RCRS_WB_FLAGS, 32'h0);
        cmp({14'h0000, rdat[0], zflag}, {14'h0000, {2{e[7:0] == 8'h00}}});
        if (!(ops[o] == OP_MUL)) cmp({14'h0000, rdat[2:1]}, {14'h0000, e[16], e[17]});
      end
    end
    // Request bits latch, clear by write, and a set beats a clear.
    base();
    pg(16, jmp(OP_JUMP, 16'h0010));
    restart();
    cmp({8'h00, status}, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      pulse(5'h01 << i);
      @(posedge clk);
      cmp({8'h00, status}, 16'h001f >> (4 - i));
    end
    @(posedge clk);
    src <= 5'h10;
    wb(1'b1, 8'h38, 32'h0);
    src <= 5'h00;
    @(posedge clk);
    cmp({8'h00, status}, 16'h0010);
    wb(1'b1, 8'h38, 32'h20);
    taken = 0;
    pulse(5'h10);
    repeat (8) @(posedge clk);
    cmp(16'(taken), 16'h0000);
    cmp({8'h00, status}, 16'h0030);
    wb(1'b1, 8'h38, 32'h60);
    pulse(5'h08);
    repeat (12) @(posedge clk);
    pulse(5'h04);
    repeat (12) @(posedge clk);
    cmp(16'(taken), 16'h0002);
    cmp({8'h00, status}, 16'h0060);
    wb(1'b0, `RCRS_WB_PC, 32'h0);
    cmp(rdat[15:0], 16'h0010);
    // Sleep: an event resumes in line, an interrupt vectors and returns.
    for (int w = 0; w < 2; w++) begin
      base();
      pg(16, jmp(OP_HALT, 16'h0000));
      pg(17, enc(OP_MOVE, 4'h1, `RCRS_AM_IMM, 8'h5a));
      pg(18, jmp(OP_JUMP, 16'h0012));
      restart();
      taken = 0;
      cmp({15'h0000, halted}, 16'h0001);
      if (w == 1) wb(1'b1, 8'h38, 32'h20);
      pulse((w == 1) ? 5'h04 : 5'h01);
      repeat (12) @(posedge clk);
      cmp({15'h0000, halted}, 16'h0000);
      cmp(16'(taken), 16'(w));
      wb(1'b0, 8'h04, 32'h0);
      cmp(rdat[15:0], 16'h005a);
    end
    // Index pairs: a store through a data index, a jump through ip.
    r = xs();
    base();
    pg(16, enc(OP_MOVE, `RCRS_REG_I1H, `RCRS_AM_IMM, r[15:8]));
    pg(17, enc(OP_MOVE, `RCRS_REG_I1L, `RCRS_AM_IMM, r[7:0]));
    pg(18, enc(OP_MOVE, 4'h2, `RCRS_AM_IMM, r[23:16]));
    pg(19, enc(OP_STORE, 4'h2, `RCRS_AM_I1, 8'h00));
    pg(20, enc(OP_MOVE, `RCRS_REG_IPH, `RCRS_AM_IMM, 8'h00));
    pg(21, enc(OP_MOVE, `RCRS_REG_IPL, `RCRS_AM_IMM, 8'h30));
    pg(22, jmp(OP_JUMPIP, 16'h0000));
    pg(48, enc(OP_MOVE, `RCRS_REG_OFFSET, `RCRS_AM_IMM, r[7:0]));
    pg(49, enc(OP_STORE, 4'h2, `RCRS_AM_I0_OFS, 8'h00));
    pg(50, jmp(OP_JUMP, 16'h0032));
    restart();
    cmp({8'h00, u_mem.dm[r[15:0]]}, {8'h00, r[23:16]});
    cmp({8'h00, u_mem.dm[{8'h00, r[7:0]}]}, {8'h00, r[23:16]});
    wb(1'b0, `RCRS_WB_PC, 32'h0);
    cmp(rdat[15:0], 16'h0032);
    // Bus round trip on a general register and an unmapped read.
    wb(1'b1, 8'h08, r);
    wb(1'b0, 8'h08, 32'h0);
    cmp(rdat[15:0], {8'h00, r[7:0]});
    wb(1'b0, 8'h80, 32'h0);
    cmp(rdat[15:0], 16'h0000);
    print_verdict();
  end
endmodule // testbench

bind rcrs_core rcrs_core_checker #(.IRQ_VECTOR(IRQ_VECTOR)) u_chk (
  .CORE_CLK(CORE_CLK), .NRST(NRST), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .PM_ADDR(PM_ADDR),
  .IRQ_LOW(IRQ_LOW), .IRQ_MID(IRQ_MID), .IRQ_HIGH(IRQ_HIGH),
  .EVT_LOW(EVT_LOW), .EVT_HIGH(EVT_HIGH), .IRQ_TAKEN(IRQ_TAKEN),
  .HALTED(HALTED), .STATUS(STATUS));
